// [design/digipot_pkg.sv]
// Purpose: shared constants for the two-wire wiper control link
// Assumes: 20 MHz system clock at both ends
// Notes: the controller registers sit on a plain strobe port
package digipot_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_QUARTER_NS = 2500; // 100 kHz serial clock
  localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // --------------------------------------------------------------
  // target address and instruction byte layout
  // --------------------------------------------------------------
  localparam logic [5:0] ADDR_UPPER = 6'h16; // 010110
  localparam int INSTR_RS_BIT = 6;
  localparam int INSTR_SD_BIT = 5;
  localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
  localparam int ACK_SLOT = 8;
  // --------------------------------------------------------------
  // controller register map (word index on the strobe port)
  // --------------------------------------------------------------
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_INSTR = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_SEL_BIT = 1;
  localparam int CMD_CNT_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
endpackage

// [design/twi_if.sv]
// Purpose: open-drain two-wire link between controller and target
// Assumes: pull-ups on both lines
// Notes: a line reads low when any party enables its driver
`timescale 1ns/100ps
`default_nettype none
interface twi_if;
  // controller drivers
  logic scl_o;
  logic scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  // target driver
  logic tgt_sda_o;
  logic tgt_sda_oe;
  // resolved wire levels
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(ctl_sda_oe & ~ctl_sda_o) & ~(tgt_sda_oe & ~tgt_sda_o);

  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
  modport controller (input scl, input sda, output scl_o, output scl_oe,
                      output ctl_sda_o, output ctl_sda_oe);
endinterface
`default_nettype wire

// [design/digipot_target.sv]
// Purpose: target end of the link holding the 256-step wiper register
// Assumes: serial clock far slower than the system clock
// Notes: all link inputs are resynchronised before use
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] shutdown opens upper terminal, wiper to lower
// [R2] shutdown keeps stored wiper, restored on exit
// [R3] writes still land during shutdown
// [R4] other instruction bits are ignored
// [R5] data byte after instruction sets wiper
// [R6] nine clocks per byte, msb first
// [R7] data line changes only while clock low
// [R8] read sends wiper straight after address ack
// [R9] controller ends read with nack, then stop
// [R10] controller ends write with stop on clock ten
// [R11] stop is data rising while clock high
// [R12] every further write byte updates wiper
// [R13] new instruction needs a fresh transfer
// [R14] repeated reads return wiper each time
// [R15] midscale reset loads 0x80
// [R16] address lsb follows select pin
// [R17] midscale reset overwrites, stays after clear
// [R18] ack own address by pulling ninth clock low
// [R19] direction bit high reads, low writes
// [R20] wiper starts at midscale after reset
// [R21] address is 010110 plus select pin
// [R22] read returns wiper even in shutdown
module digipot_target
  import digipot_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  twi_if.target bus,
  // strap
  input wire logic address_select_pin,
  // resistor array control
  output logic [7:0] wiper_code,
  output logic [7:0] resistor_array_code,
  output logic terminal_a_open,
  output logic wiper_short_b,
  output logic shutdown_bit
);
  typedef enum logic [4:0] {
    T_IDLE = 5'b00001,
    T_RECV = 5'b00010,
    T_ACK = 5'b00100,
    T_SEND = 5'b01000,
    T_MACK = 5'b10000
  } tstate_t;

  tstate_t state_ff;
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic sel_s1_ff, sel_s2_ff;
  logic [3:0] cnt_ff;
  logic [1:0] idx_ff;
  logic rw_ff;
  logic [7:0] shift_ff;
  logic drive_low_ff;
  logic mack_ff;
  logic [7:0] wiper_ff;
  logic sd_ff;
  logic [7:0] array_ff;
  logic a_open_ff;
  logic short_b_ff;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic byte_end, addr_hit, instr_take, data_take;

  // --------------------------------------------------------------
  // synchronisers and line events
  // --------------------------------------------------------------
  // two flops per pin, then one delay flop for edges
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= bus.scl;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= bus.sda;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  // select strap, resynchronised
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sel_s1_ff <= 1'b0;
      sel_s2_ff <= 1'b0;
    end
    else
    begin
      sel_s1_ff <= address_select_pin;
      sel_s2_ff <= sel_s1_ff;
    end
  end

  // edge and condition decode
  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_seen = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_seen = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff; // [R11]

  // --------------------------------------------------------------
  // byte decode
  // --------------------------------------------------------------
  // eighth bit is in when the clock falls with eight counted
  assign byte_end = (state_ff == T_RECV) && scl_fall && (cnt_ff == 4'(ACK_SLOT)) &&
                    !start_seen && !stop_seen; // [R6]
  assign addr_hit = (shift_ff[7:1] == {ADDR_UPPER, sel_s2_ff}); // [R16] [R21]
  assign instr_take = byte_end && (idx_ff == 2'd1);
  assign data_take = byte_end && (idx_ff == 2'd2); // [R5] [R12]

  // --------------------------------------------------------------
  // link state machine
  // --------------------------------------------------------------
  // bits move on clock edges; start and stop win over all
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= T_IDLE;
      cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      shift_ff <= 8'h00;
      drive_low_ff <= 1'b0;
      mack_ff <= 1'b0;
    end
    else if (start_seen)
    begin
      state_ff <= T_RECV;
      cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      drive_low_ff <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_ff <= T_IDLE;
      drive_low_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        T_IDLE:
        begin
          drive_low_ff <= 1'b0;
        end
        T_RECV:
        begin
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_s2_ff}; // msb first [R6]
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (byte_end)
          begin
            if (idx_ff != 2'd0 || addr_hit)
            begin
              // pull low on falling edge, held through ninth clock
              drive_low_ff <= 1'b1; // [R18] [R7]
              state_ff <= T_ACK;
              if (idx_ff == 2'd0)
              begin
                rw_ff <= shift_ff[0]; // [R19]
              end
            end
            else
            begin
              state_ff <= T_IDLE; // not ours: stay quiet [R18]
            end
          end
        end
        T_ACK:
        begin
          if (scl_fall)
          begin
            cnt_ff <= 4'h0;
            if (idx_ff != 2'd2)
            begin
              idx_ff <= idx_ff + 2'd1;
            end
            if (rw_ff)
            begin
              // first data bit goes out with no instruction byte [R8] [R22]
              state_ff <= T_SEND;
              shift_ff <= wiper_ff;
              drive_low_ff <= ~wiper_ff[7];
            end
            else
            begin
              state_ff <= T_RECV;
              drive_low_ff <= 1'b0;
            end
          end
        end
        T_SEND:
        begin
          if (scl_rise)
          begin
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_ff == 4'(ACK_SLOT))
            begin
              drive_low_ff <= 1'b0; // free line for controller ack
              state_ff <= T_MACK;
            end
            else
            begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              drive_low_ff <= ~shift_ff[6]; // changes only on fall [R7]
            end
          end
        end
        T_MACK:
        begin
          if (scl_rise)
          begin
            mack_ff <= ~sda_s2_ff;
          end
          else if (scl_fall)
          begin
            if (mack_ff)
            begin
              // acked: send the wiper once more [R14] [R22]
              state_ff <= T_SEND;
              cnt_ff <= 4'h0;
              shift_ff <= wiper_ff;
              drive_low_ff <= ~wiper_ff[7];
            end
            else
            begin
              state_ff <= T_IDLE; // nack: wait for stop [R9]
            end
          end
        end
        default:
        begin
          state_ff <= T_IDLE;
          drive_low_ff <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // wiper register and instruction flags
  // --------------------------------------------------------------
  // data bytes load the wiper; reset bit forces midscale
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wiper_ff <= WIPER_MIDSCALE; // [R20]
    end
    else if (data_take)
    begin
      wiper_ff <= shift_ff; // also while shut down [R3] [R12]
    end
    else if (instr_take && shift_ff[INSTR_RS_BIT])
    begin
      wiper_ff <= WIPER_MIDSCALE; // overwrites, stays after [R15] [R17]
    end
  end

  // shutdown flag; remaining instruction bits dropped [R4]
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sd_ff <= 1'b0;
    end
    else if (instr_take)
    begin
      sd_ff <= shift_ff[INSTR_SD_BIT];
    end
  end

  // --------------------------------------------------------------
  // resistor array drive
  // --------------------------------------------------------------
  // shutdown gates the array, never the stored code
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      array_ff <= WIPER_MIDSCALE;
      a_open_ff <= 1'b0;
      short_b_ff <= 1'b0;
    end
    else
    begin
      array_ff <= sd_ff ? 8'h00 : wiper_ff; // [R2] [R3]
      a_open_ff <= sd_ff; // [R1]
      short_b_ff <= sd_ff; // [R1]
    end
  end

  // outputs
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = drive_low_ff;
  assign wiper_code = wiper_ff;
  assign resistor_array_code = array_ff;
  assign terminal_a_open = a_open_ff;
  assign wiper_short_b = short_b_ff;
  assign shutdown_bit = sd_ff;
endmodule
`default_nettype wire

// [design/digipot_controller.sv]
// Purpose: bus controller end driving the wiper target
// Assumes: one target per transfer, no clock stretching
// Notes: software drives it through a small strobe register port
`timescale 1ns/100ps
`default_nettype none
module digipot_controller
  import digipot_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // link
  twi_if.controller bus
);
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_START = 4'b0010,
    C_BIT = 4'b0100,
    C_STOP = 4'b1000
  } cstate_t;

  cstate_t state_ff;
  logic [15:0] div_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [3:0] byte_ff;
  logic rw_ff, sel_ff, nack_ff;
  logic [2:0] cnt_ff;
  logic [7:0] instr_ff, data_ff, tx_ff, rx_ff, rdata_ff;
  logic scl_low_ff, sda_low_ff;
  logic sda_s1_ff, sda_s2_ff;
  logic [15:0] rdout_ff;
  logic tick, go, rx_byte, last_byte, bit_val;

  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------
  assign go = reg_wr && (reg_addr == REG_CMD) && (state_ff == C_IDLE);

  // instruction and data bytes held for the next write
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      instr_ff <= 8'h00;
      data_ff <= 8'h00;
    end
    else if (reg_wr && reg_addr == REG_INSTR)
    begin
      instr_ff <= reg_wdata[7:0];
    end
    else if (reg_wr && reg_addr == REG_DATA)
    begin
      data_ff <= reg_wdata[7:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdout_ff <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_INSTR: rdout_ff <= {8'h00, instr_ff};
        REG_DATA: rdout_ff <= {8'h00, data_ff};
        REG_STATUS: rdout_ff <= {rdata_ff, 6'h00, nack_ff, state_ff != C_IDLE};
        default: rdout_ff <= {9'h000, cnt_ff, 2'h0, sel_ff, rw_ff};
      endcase
    end
    else
    begin
      rdout_ff <= 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // quarter-bit timebase and data line sampling
  // --------------------------------------------------------------
  assign tick = (div_ff == 16'(QUARTER - 1));

  always_ff @(posedge clock)
  begin
    if (!rst_n || state_ff == C_IDLE)
    begin
      div_ff <= 16'h0000;
    end
    else
    begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end
    else
    begin
      sda_s1_ff <= bus.sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  // byte 0 is the address; a read receives every later byte
  assign rx_byte = rw_ff && (byte_ff != 4'h0);
  assign last_byte = rw_ff ? (byte_ff == {1'b0, cnt_ff} + 4'h1) : (byte_ff == 4'h2);
  assign bit_val = (bit_ff == 4'(ACK_SLOT)) ? (rx_byte ? last_byte : 1'b1) // nack last [R9]
                                            : (rx_byte ? 1'b1 : tx_ff[7]);

  // --------------------------------------------------------------
  // transfer sequencer
  // --------------------------------------------------------------
  // clock rises at quarter 2; data moves at quarter 1, except the stop rise at quarter 3
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= C_IDLE;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 4'h0;
      rw_ff <= 1'b0;
      sel_ff <= 1'b0;
      cnt_ff <= 3'h0;
      nack_ff <= 1'b0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      rdata_ff <= 8'h00;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end
    else if (go)
    begin
      state_ff <= C_START;
      q_ff <= 2'h0;
      rw_ff <= reg_wdata[CMD_READ_BIT];
      sel_ff <= reg_wdata[CMD_SEL_BIT];
      cnt_ff <= reg_wdata[CMD_CNT_LSB +: 3];
      nack_ff <= 1'b0;
      tx_ff <= {ADDR_UPPER, reg_wdata[CMD_SEL_BIT], reg_wdata[CMD_READ_BIT]}; // [R13] [R19]
    end
    else if (tick)
    begin
      q_ff <= q_ff + 2'h1;
      case (state_ff)
        C_START:
        begin
          if (q_ff == 2'h0)
          begin
            sda_low_ff <= 1'b1; // data falls, clock high
          end
          else if (q_ff == 2'h1)
          begin
            scl_low_ff <= 1'b1;
          end
          else if (q_ff == 2'h3)
          begin
            state_ff <= C_BIT;
            bit_ff <= 4'h0;
            byte_ff <= 4'h0;
          end
        end
        C_BIT:
        begin
          if (q_ff == 2'h0)
          begin
            sda_low_ff <= ~bit_val; // clock is low here [R7]
          end
          else if (q_ff == 2'h1)
          begin
            scl_low_ff <= 1'b0;
          end
          else if (q_ff == 2'h2)
          begin
            if (bit_ff == 4'(ACK_SLOT) && !rx_byte)
            begin
              nack_ff <= sda_s2_ff;
            end
            else if (bit_ff != 4'(ACK_SLOT))
            begin
              rx_ff <= {rx_ff[6:0], sda_s2_ff};
              if (bit_ff == 4'h7 && rx_byte)
              begin
                rdata_ff <= {rx_ff[6:0], sda_s2_ff};
              end
            end
          end
          else
          begin
            scl_low_ff <= 1'b1;
            if (bit_ff == 4'(ACK_SLOT))
            begin
              bit_ff <= 4'h0;
              byte_ff <= byte_ff + 4'h1;
              tx_ff <= (byte_ff == 4'h0) ? instr_ff : data_ff;
              if (nack_ff || last_byte)
              begin
                state_ff <= C_STOP;
              end
            end
            else
            begin
              bit_ff <= bit_ff + 4'h1;
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          end
        end
        C_STOP:
        begin
          if (q_ff == 2'h0)
          begin
            sda_low_ff <= 1'b1;
          end
          else if (q_ff == 2'h1)
          begin
            scl_low_ff <= 1'b0;
          end
          else if (q_ff == 2'h2)
          begin
            sda_low_ff <= 1'b0; // data rises, clock high [R10] [R11]
          end
          else
          begin
            state_ff <= C_IDLE;
          end
        end
        default:
        begin
          state_ff <= C_IDLE;
        end
      endcase
    end
  end

  // open-drain outputs
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_low_ff;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe = sda_low_ff;
  assign reg_rdata = rdout_ff;
endmodule
`default_nettype wire

// [tb/digipot_asserts.sv]
// Purpose: assertions on the two-wire link and the wiper outputs
// Assumes: controller built with a quarter bit of 8 clocks
// Notes: watches the resolved clock and tgt_sda_oe beside the interface
`timescale 1ns/100ps
`default_nettype none
module digipot_asserts
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  input wire logic scl,
  input wire logic tgt_sda_oe,
  // target outputs
  input wire logic [7:0] wiper_code,
  input wire logic [7:0] resistor_array_code,
  input wire logic terminal_a_open,
  input wire logic wiper_short_b,
  input wire logic shutdown_bit
);
  // ----------------------------------------------------------
  // link timing and wiper behaviour
  // ----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // target data held through the clock high phase
  tgt_hold_a: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe))
    else $error("target data moved with clock high");
  tgt_launch_a: assert property ($changed(tgt_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("target data changed too near a clock edge");
  // each bit keeps the clock low at least one quarter
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("serial clock low phase too short");
  // shutdown and wiper output behaviour
  sd_zero_a: assert property (shutdown_bit |=> resistor_array_code == 8'h00)
    else $error("array not zero in shutdown");
  sd_flags_a: assert property ($stable(shutdown_bit) |->
    terminal_a_open == shutdown_bit && wiper_short_b == shutdown_bit)
    else $error("terminal flags disagree with shutdown");
  array_follow_a: assert property (!shutdown_bit |=>
    resistor_array_code == $past(wiper_code))
    else $error("array does not follow wiper");
  sd_keep_a: assert property ($rose(shutdown_bit) |-> $stable(wiper_code))
    else $error("wiper disturbed by shutdown");
  wiper_when_a: assert property ($changed(wiper_code) |-> !scl)
    else $error("wiper updated with clock high");

  // main scenarios reached
  cover property ($rose(shutdown_bit));
  cover property ($rose(tgt_sda_oe));
  cover property ($changed(wiper_code));
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for controller and target joined
// Assumes: quarter bit shortened to 8 clocks
// Notes: software view through the controller register port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import digipot_pkg::*;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic pin_sel = 1'b0;
  logic [7:0] wiper_code;
  logic [7:0] resistor_array_code;
  logic terminal_a_open;
  logic wiper_short_b;
  logic shutdown_bit;
  logic [15:0] rd_val;
  logic saw_mid = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] addr_byte = 8'h00;
  int bit_cnt = 0;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  twi_if i_twi_if ();
  digipot_controller #(.QUARTER(8)) i_digipot_controller (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus(i_twi_if.controller));
  digipot_target i_digipot_target (.clock(clock), .rst_n(rst_n), .bus(i_twi_if.target),
    .address_select_pin(pin_sel), .wiper_code(wiper_code),
    .resistor_array_code(resistor_array_code), .terminal_a_open(terminal_a_open),
    .wiper_short_b(wiper_short_b), .shutdown_bit(shutdown_bit));
  digipot_asserts i_digipot_asserts (.clock(clock), .rst_n(rst_n), .scl(i_twi_if.scl),
    .tgt_sda_oe(i_twi_if.tgt_sda_oe), .wiper_code(wiper_code),
    .resistor_array_code(resistor_array_code), .terminal_a_open(terminal_a_open),
    .wiper_short_b(wiper_short_b), .shutdown_bit(shutdown_bit));

  // wire monitor: clock rises since start, first byte, midscale per transfer
  always @(posedge clock)
  begin
    scl_q <= i_twi_if.scl;
    sda_q <= i_twi_if.sda;
    if (wiper_code === 8'h80)
      saw_mid <= 1'b1;
    if (i_twi_if.scl && scl_q && sda_q && !i_twi_if.sda)
    begin
      bit_cnt <= 0;
      saw_mid <= 1'b0;
    end
    else if (i_twi_if.scl && !scl_q)
    begin
      bit_cnt <= bit_cnt + 1;
      if (bit_cnt < 8)
        addr_byte <= {addr_byte[6:0], i_twi_if.sda};
    end
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    // read data stands in the cycle after the strobe; take it at its closing edge
    @(posedge clock);
    d = reg_rdata;
  endtask

  // start a transfer and poll busy under a bound
  task automatic run_cmd(input logic rw, input logic sel, input logic [2:0] cnt);
    int n;
    n = 0;
    reg_write(REG_CMD, {9'h000, cnt, 2'b00, sel, rw});
    rd_val = 16'h0001;
    while (rd_val[STAT_BUSY_BIT] !== 1'b0 && n < 2000)
    begin
      reg_read(REG_STATUS, rd_val);
      n++;
    end
    check("busy", 16'h0000, {15'h0000, rd_val[STAT_BUSY_BIT]});
    @(posedge clock);
    @(posedge clock);
  endtask

  task automatic write_xfer(input logic [7:0] ins, input logic [7:0] dat, input logic sel);
    reg_write(REG_INSTR, {8'h00, ins});
    reg_write(REG_DATA, {8'h00, dat});
    run_cmd(1'b0, sel, 3'h0);
  endtask

  task automatic check_out(input logic [7:0] wip, input logic [7:0] arr, input logic sd);
    check("wiper", {8'h00, wip}, {8'h00, wiper_code});
    check("array", {8'h00, arr}, {8'h00, resistor_array_code});
    check("flags", {13'h0000, sd, sd, sd},
      {13'h0000, shutdown_bit, terminal_a_open, wiper_short_b});
  endtask

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_out(WIPER_MIDSCALE, WIPER_MIDSCALE, 1'b0);
    $display("test reset done");
    write_xfer(8'h00, 8'h3c, 1'b0);
    check("addr_w", {8'h00, ADDR_UPPER, 2'b00}, {8'h00, addr_byte});
    check("clocks_w", 16'd28, bit_cnt[15:0]);
    reg_read(REG_STATUS, rd_val);
    check("ack_w", 16'h0000, {15'h0000, rd_val[STAT_NACK_BIT]});
    check_out(8'h3c, 8'h3c, 1'b0);
    $display("test write done");
    run_cmd(1'b1, 1'b0, 3'h1);
    reg_read(REG_STATUS, rd_val);
    check("read_two", 16'h003c, {8'h00, rd_val[15:8]});
    reg_read(REG_CMD, rd_val);
    check("cmd_rb", 16'h0011, rd_val);
    check("addr_r", {8'h00, ADDR_UPPER, 2'b01}, {8'h00, addr_byte});
    check("clocks_r", 16'd28, bit_cnt[15:0]);
    $display("test read done");
    write_xfer(8'h20, 8'h55, 1'b0);
    check_out(8'h55, 8'h00, 1'b1);
    run_cmd(1'b1, 1'b0, 3'h0);
    reg_read(REG_STATUS, rd_val);
    check("read_sd", 16'h0055, {8'h00, rd_val[15:8]});
    write_xfer(8'h9f, 8'h12, 1'b0);
    check_out(8'h12, 8'h12, 1'b0);
    $display("test shutdown done");
    write_xfer(8'h40, 8'h77, 1'b0);
    check("midscale_seen", 16'h0001, {15'h0000, saw_mid});
    check_out(8'h77, 8'h77, 1'b0);
    $display("test midscale done");
    write_xfer(8'h00, 8'h99, 1'b1);
    reg_read(REG_STATUS, rd_val);
    check("nack_other", 16'h0001, {15'h0000, rd_val[STAT_NACK_BIT]});
    check_out(8'h77, 8'h77, 1'b0);
    pin_sel <= 1'b1;
    repeat (4) @(posedge clock);
    write_xfer(8'h00, 8'h99, 1'b1);
    reg_read(REG_STATUS, rd_val);
    check("ack_sel", 16'h0000, {15'h0000, rd_val[STAT_NACK_BIT]});
    check_out(8'h99, 8'h99, 1'b0);
    $display("test address done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_out(WIPER_MIDSCALE, WIPER_MIDSCALE, 1'b0);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
